/* File: src/program_sequencer_stack.v */
// Four-phase instruction sequencer with return stack, ALU and APB registers.
// Instruction word: [15:14]=11 jump (bit13=0) or call (bit13=1) to [12:0];
// otherwise bit15 marks the extended form, [14:10] opcode, [9] memory
// destination, [8] immediate operand, [7:0] data address or immediate.
`include "seq_regs.vh"
module program_sequencer_stack #(
  parameter STACK_AW = 3
) (
  // Clock and reset.
  input  wire        i_sys_clk,
  input  wire        i_sys_rst,
  // APB slave.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Program memory fetch port, data valid one cycle after the request.
  output reg         o_fetch_req,
  output wire [13:0] o_fetch_addr,
  input  wire [15:0] i_fetch_data,
  // Data memory port, read data valid one cycle after the strobe.
  output reg         o_dmem_rd,
  output reg         o_dmem_we,
  output reg  [7:0]  o_dmem_addr,
  output reg  [7:0]  o_dmem_wdata,
  input  wire [7:0]  i_dmem_rdata,
  // Interrupt request from on-chip logic and its acknowledge.
  input  wire        i_irq_req,
  output reg         o_irq_ack,
  // Phase indicator, one-hot, bit 0 is phase one.
  output reg  [3:0]  o_cycle_phases
);

  localparam DEPTH = 1 << STACK_AW;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  reg [12:0]         pc_reg;
  reg [15:0]         fetch_buf_reg;
  reg [15:0]         ir_reg;
  reg                ir_valid_reg;
  reg                ext_done_reg;
  reg                stall_reg;
  reg [7:0]          acc_reg;
  reg [7:0]          opnd_reg;
  reg [3:0]          flags_reg;
  reg                gie_reg;
  reg                prog_bank_select_bit;
  reg                irq_pend_reg;
  reg                ovf_reg;
  reg                pcl_wr_pend_reg;
  reg [7:0]          pcl_wr_data_reg;
  reg [13:0]         stack_mem [0:DEPTH-1];
  reg [STACK_AW-1:0] top_reg;
  reg [STACK_AW:0]   sp_reg;

  wire stack_full = (sp_reg == {1'b1, {STACK_AW{1'b0}}});
  wire t1 = o_cycle_phases[0];
  wire t2 = o_cycle_phases[1];
  wire t3 = o_cycle_phases[2];
  wire t4 = o_cycle_phases[3];

  assign o_fetch_addr = {prog_bank_select_bit, pc_reg};

  // ---------------------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------------------
  // Zero wait states keep the register path out of the phase timing.
  wire apb_wr = psel & penable & pwrite;
  wire hit_pcl  = (paddr == `PCL_OFS);
  wire hit_ctrl = (paddr == `CTRL_OFS);
  wire hit_stat = (paddr == `STAT_OFS);
  wire hit_acc  = (paddr == `ACC_OFS);
  wire hit_any  = hit_pcl | hit_ctrl | hit_stat | hit_acc;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // Caught at setup, held through access; the stack stays hidden.
  always @(posedge i_sys_clk) begin
    if (psel && !penable) begin
      prdata <= 32'h0000_0000;
      if (hit_pcl)
        prdata[7:0] <= pc_reg[7:0];
      if (hit_ctrl) begin
        prdata[`CTRL_GIE]  <= gie_reg;
        prdata[`CTRL_BANK] <= prog_bank_select_bit;
      end
      if (hit_stat) begin
        prdata[3:0]      <= flags_reg;
        prdata[`ST_FULL] <= stack_full;
        prdata[`ST_OVF]  <= ovf_reg;
      end
      if (hit_acc)
        prdata[7:0] <= acc_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  wire       is_jc   = (ir_reg[15:14] == 2'b11);
  wire       is_call = is_jc & ir_reg[13];
  wire       is_ext  = ir_reg[15] & ~is_jc;
  wire [4:0] op      = ir_reg[14:10];
  wire       to_mem  = ir_reg[9];
  wire       use_imm = ir_reg[8];
  wire [7:0] b_val   = use_imm ? ir_reg[7:0] : opnd_reg;
  // Extended forms spend their first cycle as a stall.
  wire       exec    = ir_valid_reg & (~is_ext | ext_done_reg);

  // ---------------------------------------------------------------------------
  // ALU
  // ---------------------------------------------------------------------------
  reg [8:0] sum;
  reg [7:0] res;
  reg [3:0] flg;
  reg       wr_res;
  reg       skip;
  reg       ovr;
  // Eight-bit datapath; Z follows the result of every operation except moves, rotates, SZ, SNZ, NOP and the two returns.
  always @* begin
    sum    = 9'h000;
    res    = acc_reg;
    flg    = flags_reg;
    wr_res = 1'b1;
    skip   = 1'b0;
    ovr    = 1'b0;
    case (op)
      `OP_ADD, `OP_ADC: begin
        sum = {1'b0, acc_reg} + {1'b0, b_val}
              + {8'h00, op == `OP_ADC && flags_reg[`ST_C]};
        res = sum[7:0];
        flg[`ST_C]  = sum[8];
        flg[`ST_AC] = ({1'b0, acc_reg[3:0]} + {1'b0, b_val[3:0]}
                       + {4'h0, op == `OP_ADC && flags_reg[`ST_C]}) > 5'h0f;
        ovr = (acc_reg[7] == b_val[7]) && (res[7] != acc_reg[7]);
      end
      `OP_SUB, `OP_SBC: begin
        // Carry set means no borrow.
        sum = {1'b0, acc_reg} - {1'b0, b_val}
              - {8'h00, op == `OP_SBC && !flags_reg[`ST_C]};
        res = sum[7:0];
        flg[`ST_C]  = ~sum[8];
        flg[`ST_AC] = acc_reg[3:0] >= b_val[3:0];
        ovr = (acc_reg[7] != b_val[7]) && (res[7] != acc_reg[7]);
      end
      `OP_DAA: begin
        sum = {1'b0, acc_reg};
        if (acc_reg[3:0] > 4'h9 || flags_reg[`ST_AC])
          sum = sum + 9'h006;
        if (sum[7:4] > 4'h9 || flags_reg[`ST_C] || sum[8])
          sum = sum + 9'h060;
        res = sum[7:0];
        flg[`ST_C] = sum[8] | flags_reg[`ST_C];
      end
      `OP_AND: res = acc_reg & b_val;
      `OP_OR:  res = acc_reg | b_val;
      `OP_XOR: res = acc_reg ^ b_val;
      `OP_CPL: res = ~b_val;
      `OP_RR:  res = {b_val[0], b_val[7:1]};
      `OP_RL:  res = {b_val[6:0], b_val[7]};
      `OP_RRC: begin
        res = {flags_reg[`ST_C], b_val[7:1]};
        flg[`ST_C] = b_val[0];
      end
      `OP_RLC: begin
        res = {b_val[6:0], flags_reg[`ST_C]};
        flg[`ST_C] = b_val[7];
      end
      `OP_INC, `OP_SIZ: res = b_val + 8'h01;
      `OP_DEC, `OP_SDZ: res = b_val - 8'h01;
      `OP_SZ, `OP_SNZ: begin
        res    = b_val;
        wr_res = 1'b0;
      end
      `OP_MOV: res = to_mem ? acc_reg : b_val;
      default: wr_res = 1'b0;
    endcase
    // Skip decisions look at the fresh result.
    case (op)
      `OP_SZ, `OP_SIZ, `OP_SDZ: skip = (res == 8'h00);
      `OP_SNZ:                  skip = (res != 8'h00);
      default:                  skip = 1'b0;
    endcase
    if (wr_res && op != `OP_MOV && op != `OP_RRC && op != `OP_RLC
        && op != `OP_RR && op != `OP_RL)
      flg[`ST_Z] = (res == 8'h00);
    if (op == `OP_ADD || op == `OP_ADC || op == `OP_SUB || op == `OP_SBC)
      flg[`ST_OV] = ovr;
  end

  // ---------------------------------------------------------------------------
  // Flow control decision at the end of phase four
  // ---------------------------------------------------------------------------
  wire hold_ext = ir_valid_reg & is_ext & ~ext_done_reg;
  wire do_ret  = exec & ~is_jc & ((op == `OP_RET) | (op == `OP_INTERRUPT_RETURN));
  wire do_jmp  = exec & is_jc;
  wire do_skip = exec & ~is_jc & skip;
  // Low byte writes and interrupts wait out an extended stall, which
  // would otherwise replay a stale prefetch; one redirect at a time.
  wire do_pcl  = pcl_wr_pend_reg & ~do_jmp & ~do_ret & ~do_skip & ~hold_ext;
  wire can_irq = ~do_jmp & ~do_ret & ~do_skip & ~do_pcl & ~hold_ext;
  wire take_irq = can_irq & irq_pend_reg & gie_reg & ~stack_full;
  wire [STACK_AW-1:0] top_dec = top_reg - {{(STACK_AW-1){1'b0}}, 1'b1};
  wire [13:0] pop_val = stack_mem[top_dec];
  // Address of the prefetched instruction that an interrupt discards.
  wire [12:0] pc_back = pc_reg - 13'h0001;

  // ---------------------------------------------------------------------------
  // Phase generator
  // ---------------------------------------------------------------------------
  // One-hot rotation keeps the phases non-overlapping by construction.
  always @(posedge i_sys_clk) begin
    if (i_sys_rst)
      o_cycle_phases <= 4'h1;
    else
      o_cycle_phases <= {o_cycle_phases[2:0], o_cycle_phases[3]};
  end

  // ---------------------------------------------------------------------------
  // Fetch, counter and pipeline registers
  // ---------------------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      pc_reg        <= `PC_RST;
      fetch_buf_reg <= 16'h0000;
      ir_reg        <= 16'h0000;
      ir_valid_reg  <= 1'b0;
      ext_done_reg  <= 1'b0;
      stall_reg     <= 1'b0;
      o_fetch_req   <= 1'b1;
      o_irq_ack     <= 1'b0;
    end else begin
      o_irq_ack <= 1'b0;
      if (t1) begin
        o_fetch_req <= 1'b0;
        if (!stall_reg)
          pc_reg <= pc_reg + 13'h0001;
      end
      // Fetch data arrives in phase two, while execution runs on.
      if (t2 && !stall_reg)
        fetch_buf_reg <= i_fetch_data;
      if (t4) begin
        stall_reg    <= hold_ext;
        o_fetch_req  <= ~hold_ext;
        ext_done_reg <= hold_ext;
        if (!hold_ext) begin
          ir_reg       <= fetch_buf_reg;
          ir_valid_reg <= 1'b1;
        end
        if (do_jmp) begin
          pc_reg       <= ir_reg[12:0];
          ir_valid_reg <= 1'b0;
        end else if (do_ret) begin
          pc_reg       <= pop_val[12:0];
          ir_valid_reg <= 1'b0;
        end else if (do_skip) begin
          ir_valid_reg <= 1'b0;
        end else if (do_pcl) begin
          pc_reg       <= {pc_reg[12:8], pcl_wr_data_reg};
          ir_valid_reg <= 1'b0;
        end else if (take_irq) begin
          pc_reg       <= `IRQ_VEC;
          ir_valid_reg <= 1'b0;
          o_irq_ack    <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Return stack
  // ---------------------------------------------------------------------------
  // A circular store lets an overflowing call overwrite the oldest entry.
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      top_reg <= {STACK_AW{1'b0}};
      sp_reg  <= {(STACK_AW+1){1'b0}};
      ovf_reg <= 1'b0;
    end else begin
      if (apb_wr && hit_stat && pwdata[`ST_OVF])
        ovf_reg <= 1'b0;
      if (t4 && (do_jmp && is_call || take_irq)) begin
        stack_mem[top_reg] <= {prog_bank_select_bit, pc_back};
        top_reg <= top_reg + {{(STACK_AW-1){1'b0}}, 1'b1};
        if (stack_full)
          ovf_reg <= 1'b1;
        else
          sp_reg <= sp_reg + {{STACK_AW{1'b0}}, 1'b1};
      end else if (t4 && do_ret) begin
        top_reg <= top_dec;
        if (sp_reg != {(STACK_AW+1){1'b0}})
          sp_reg <= sp_reg - {{STACK_AW{1'b0}}, 1'b1};
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Data memory access and write-back
  // ---------------------------------------------------------------------------
  // Phase two reads the operand, phase three captures it, phase four commits.
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_dmem_rd    <= 1'b0;
      o_dmem_we    <= 1'b0;
      o_dmem_addr  <= 8'h00;
      o_dmem_wdata <= 8'h00;
      opnd_reg     <= 8'h00;
      acc_reg      <= 8'h00;
      flags_reg    <= 4'h0;
    end else begin
      o_dmem_we <= 1'b0;
      o_dmem_rd <= t1 & ir_valid_reg & ~is_jc & ~use_imm;
      if (t1)
        o_dmem_addr <= ir_reg[7:0];
      if (t3)
        opnd_reg <= i_dmem_rdata;
      if (t4 && exec && !is_jc) begin
        flags_reg <= flg;
        if (wr_res) begin
          if (to_mem) begin
            o_dmem_we    <= 1'b1;
            o_dmem_wdata <= res;
          end else begin
            acc_reg <= res;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Control register, low byte write and interrupt latch
  // ---------------------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      gie_reg              <= `GIE_RST;
      prog_bank_select_bit <= `BANK_RST;
      irq_pend_reg         <= 1'b0;
      pcl_wr_pend_reg      <= 1'b0;
      pcl_wr_data_reg      <= 8'h00;
    end else begin
      if (apb_wr && hit_ctrl) begin
        gie_reg              <= pwdata[`CTRL_GIE];
        prog_bank_select_bit <= pwdata[`CTRL_BANK];
      end
      // The write is held until the next phase four redirect slot.
      if (apb_wr && hit_pcl) begin
        pcl_wr_pend_reg <= 1'b1;
        pcl_wr_data_reg <= pwdata[7:0];
      end else if (t4 && do_pcl) begin
        pcl_wr_pend_reg <= 1'b0;
      end
      // Acknowledge masks further interrupts; interrupt return reopens.
      if (t4 && take_irq)
        gie_reg <= 1'b0;
      else if (t4 && do_ret && op == `OP_INTERRUPT_RETURN)
        gie_reg <= 1'b1;
      if (t4 && do_ret)
        prog_bank_select_bit <= pop_val[13];
      // A new request in the acknowledge cycle stays latched.
      if (i_irq_req)
        irq_pend_reg <= 1'b1;
      else if (t4 && take_irq)
        irq_pend_reg <= 1'b0;
    end
  end

endmodule

/* File: src/seq_regs.vh */
// Register offsets, field positions, reset values and opcodes of the sequencer.
`ifndef SEQ_REGS_VH
`define SEQ_REGS_VH
// ----------------------------------------------------------------------------
// APB register offsets
// ----------------------------------------------------------------------------
`define PCL_OFS      12'h000
`define CTRL_OFS     12'h004
`define STAT_OFS     12'h008
`define ACC_OFS      12'h00c
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTRL_GIE     0
`define CTRL_BANK    1
`define ST_C         0
`define ST_AC        1
`define ST_Z         2
`define ST_OV        3
`define ST_FULL      4
`define ST_OVF       5
// ----------------------------------------------------------------------------
// Reset values and interrupt vector
// ----------------------------------------------------------------------------
`define PC_RST       13'h0000
`define GIE_RST      1'h0
`define BANK_RST     1'h0
`define IRQ_VEC      13'h0004
// ----------------------------------------------------------------------------
// Operation codes, instruction bits [14:10]
// ----------------------------------------------------------------------------
`define OP_NOP  5'h00
`define OP_ADD  5'h01
`define OP_ADC  5'h02
`define OP_SUB  5'h03
`define OP_SBC  5'h04
`define OP_DAA  5'h05
`define OP_AND  5'h06
`define OP_OR   5'h07
`define OP_XOR  5'h08
`define OP_CPL  5'h09
`define OP_RR   5'h0a
`define OP_RRC  5'h0b
`define OP_RL   5'h0c
`define OP_RLC  5'h0d
`define OP_INC  5'h0e
`define OP_DEC  5'h0f
`define OP_SZ   5'h10
`define OP_SNZ  5'h11
`define OP_SIZ  5'h12
`define OP_SDZ  5'h13
`define OP_RET  5'h14
`define OP_INTERRUPT_RETURN 5'h15
`define OP_MOV  5'h16
`endif

/* File: tb/mem_model.sv */
// Program and data memory facing the sequencer.
module mem_model (
  // Clock.
  input  wire         i_sys_clk,
  // Fetch port.
  input  wire         i_fetch_req,
  input  wire  [13:0] i_fetch_addr,
  output logic [15:0] o_fetch_data,
  // Data port.
  input  wire         i_dmem_rd,
  input  wire         i_dmem_we,
  input  wire  [7:0]  i_dmem_addr,
  input  wire  [7:0]  i_dmem_wdata,
  output logic [7:0]  o_dmem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rom [0:255];
  logic [7:0]  ram [0:255];
  // Blank code and cleared data; the bench loads its program later.
  initial begin
    o_fetch_data = 16'h0000;
    o_dmem_rdata = 8'h00;
    for (int i = 0; i < 256; i++) begin
      rom[i] = 16'h0000;
      ram[i] = 8'h00;
    end
  end
  // Data is valid only the cycle after a request; otherwise it toggles,
  // so a late sample cannot be rescued by a stale value.
  always @(posedge i_sys_clk) begin
    o_fetch_data <= i_fetch_req ? rom[i_fetch_addr[7:0]] : ~o_fetch_data;
    o_dmem_rdata <= i_dmem_rd ? ram[i_dmem_addr] : ~o_dmem_rdata;
    if (i_dmem_we) begin
      ram[i_dmem_addr] <= i_dmem_wdata;
    end
  end
endmodule

/* File: tb/seq_chk.sv */
// Port-level assertions for the program sequencer.
module seq_chk #(
  parameter STACK_AW = 3
) (
  // Clock and reset.
  input wire        i_sys_clk,
  input wire        i_sys_rst,
  // Register bus.
  input wire        psel,
  input wire        penable,
  input wire [11:0] paddr,
  input wire        pslverr,
  // Memory ports and status.
  input wire        o_fetch_req,
  input wire [13:0] o_fetch_addr,
  input wire        o_dmem_rd,
  input wire        o_dmem_we,
  input wire        o_irq_ack,
  input wire [3:0]  o_cycle_phases
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // Timing frame
  // ------------------------------------------------------------------
  // One clock domain, so one clocking and one reset guard serve all.
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  // The three later phases of a cycle, then the wrap to phase one.
  sequence phase_tail;
    o_cycle_phases == 4'h2 ##1 o_cycle_phases == 4'h4 ##1
    o_cycle_phases == 4'h8 ##1 o_cycle_phases == 4'h1;
  endsequence
  // Vector fetch, allowed up to two instruction cycles late.
  sequence vector_fetch;
    ##[0:8] (o_fetch_req && o_fetch_addr[12:0] == 13'h0004);
  endsequence
  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  AST_PHASE_ROTATE: assert property (
    o_cycle_phases == 4'h1 |=> phase_tail) else $error("Phase slip.");
  AST_FETCH_PHASE: assert property (
    o_fetch_req |-> o_cycle_phases == 4'h1) else $error("Stray fetch.");
  AST_FETCH_SPACING: assert property (
    o_fetch_req |=> !o_fetch_req [*3]) else $error("Fetch too soon.");
  AST_OPERAND_READ: assert property (
    o_dmem_rd |-> o_cycle_phases == 4'h2) else $error("Stray read.");
  AST_WRITE_BACK: assert property (
    o_dmem_we |-> o_cycle_phases == 4'h1 ##1 !o_dmem_we [*3])
    else $error("Bad write back.");
  AST_ACK_VECTOR: assert property (
    o_irq_ack |-> vector_fetch) else $error("No vector fetch.");
  AST_ACK_SINGLE: assert property (
    o_irq_ack |=> !o_irq_ack [*8]) else $error("Repeated ack.");
  AST_RESET_START: assert property (
    $fell(i_sys_rst) |-> o_cycle_phases == 4'h1 && o_fetch_req &&
    o_fetch_addr == 14'h0000) else $error("Bad start.");
  AST_UNMAPPED: assert property (
    psel && penable && paddr[11:4] != 8'h00 |-> pslverr)
    else $error("Unmapped access accepted.");
endmodule
bind program_sequencer_stack seq_chk #(.STACK_AW(STACK_AW)) u_seq_chk (
  .i_sys_clk, .i_sys_rst, .psel, .penable, .paddr, .pslverr, .o_fetch_req,
  .o_fetch_addr, .o_dmem_rd, .o_dmem_we, .o_irq_ack, .o_cycle_phases
);

/* File: tb/testbench.sv */
// Self-checking bench for the program sequencer and its return stack.
`define CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
`include "seq_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_sys_clk, i_sys_rst, psel, penable, pwrite, i_irq_req, err;
  logic [11:0] paddr;
  logic [12:0] watch;
  logic [31:0] pwdata, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, o_fetch_req, o_dmem_rd, o_dmem_we, o_irq_ack;
  wire  [13:0] o_fetch_addr;
  wire  [15:0] i_fetch_data;
  wire  [7:0]  o_dmem_addr, o_dmem_wdata, i_dmem_rdata;
  wire  [3:0]  o_cycle_phases;
  int          bad_count, tests_run, ack_cnt, hit_cnt;
  // A four-deep stack keeps the overflow run short.
  program_sequencer_stack #(.STACK_AW(2)) u_program_sequencer_stack (
    .i_sys_clk, .i_sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .o_fetch_req, .o_fetch_addr, .i_fetch_data,
    .o_dmem_rd, .o_dmem_we, .o_dmem_addr, .o_dmem_wdata, .i_dmem_rdata,
    .i_irq_req, .o_irq_ack, .o_cycle_phases
  );
  mem_model u_mem_model (
    .i_sys_clk, .i_fetch_req(o_fetch_req), .i_fetch_addr(o_fetch_addr),
    .o_fetch_data(i_fetch_data), .i_dmem_rd(o_dmem_rd),
    .i_dmem_we(o_dmem_we), .i_dmem_addr(o_dmem_addr),
    .i_dmem_wdata(o_dmem_wdata), .o_dmem_rdata(i_dmem_rdata)
  );
  // ------------------------------------------------------------------
  // Clock, monitor and tasks
  // ------------------------------------------------------------------
  // 250 MHz system clock.
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  // Count acknowledges and fetches of the watched address.
  always @(posedge i_sys_clk) begin
    if (o_irq_ack === 1'b1) begin
      ack_cnt++;
    end
    if (o_fetch_req === 1'b1 && o_fetch_addr[12:0] === watch) begin
      hit_cnt++;
    end
  end
  task automatic ld(input logic [7:0] a, input logic [15:0] w);
    u_mem_model.rom[a] <= w;
  endtask
  // One APB transfer, always entered just after a rising edge.
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] wd);
    logic mapped;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_sys_clk);
    end while (pready !== 1'b1);
    mapped = a inside {`PCL_OFS, `CTRL_OFS, `STAT_OFS, `ACC_OFS};
    `CHK(pslverr, !mapped)
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge i_sys_clk);
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial begin
    i_sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    i_irq_req = 1'b0;
    watch = 13'h0030;
    @(posedge i_sys_clk);
    // Main line: ALU work, a memory round trip, a taken skip, a loop.
    ld(8'h00, 16'hc008);
    ld(8'h04, 16'hc004);
    ld(8'h08, 16'h595a);
    ld(8'h09, 16'h5a20);
    ld(8'h0a, 16'h3a20);
    ld(8'h0b, 16'h05a6);
    ld(8'h0c, 16'h4420);
    ld(8'h0d, 16'h0501);
    ld(8'h0e, 16'hc00e);
    // Five nested calls, one more than the stack holds.
    ld(8'h30, 16'he040);
    for (int i = 0; i < 4; i++) begin
      ld(8'h40 + 8'(i), 16'he041 + 16'(i));
    end
    ld(8'h44, 16'hc044);
    repeat (19) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_sys_clk);
    xfer(1'b0, `STAT_OFS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    xfer(1'b0, `CTRL_OFS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    xfer(1'b0, 12'h010, 32'h0000_0000);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    repeat (120) @(posedge i_sys_clk);
    xfer(1'b0, `ACC_OFS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    xfer(1'b0, `STAT_OFS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0007)
    `CHK(u_mem_model.ram[8'h20], 8'h5b)
    // In-page jump through the low byte into the call chain.
    hit_cnt = 0;
    xfer(1'b1, `PCL_OFS, 32'h0000_0030);
    repeat (100) @(posedge i_sys_clk);
    `CHK(hit_cnt != 0, 1'b1)
    xfer(1'b0, `STAT_OFS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0037)
    xfer(1'b1, `STAT_OFS, 32'h0000_0020);
    xfer(1'b0, `STAT_OFS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0017)
    // With the stack full the request is held, not acknowledged.
    xfer(1'b1, `CTRL_OFS, 32'h0000_0001);
    ack_cnt = 0;
    i_irq_req <= 1'b1;
    @(posedge i_sys_clk);
    i_irq_req <= 1'b0;
    repeat (40) @(posedge i_sys_clk);
    `CHK(ack_cnt, 0)
    // A return frees one level and lets the held request in.
    watch = `IRQ_VEC;
    hit_cnt = 0;
    ld(8'h44, 16'h5000);
    repeat (60) @(posedge i_sys_clk);
    `CHK(ack_cnt, 1)
    `CHK(hit_cnt != 0, 1'b1)
    xfer(1'b0, `CTRL_OFS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    tally_and_finish();
  end
  // Watchdog well beyond the roughly 375 cycles the sequence needs.
  initial begin
    repeat (3000) @(posedge i_sys_clk);
    bad_count++;
    tally_and_finish();
  end
endmodule
